// ### psq_pkg.sv
// What this block does
// - Ten-bit program address holds next instruction
// - Non-branching instruction advances by its length
// - Five jump kinds load operand target
// - Call saves address, then loads target
// - Return reloads address from return register
// - Any reset zeroes program address
// - Depth bit increments on call, decrements on return
// - Reset clears depth bit
// - Overflow or underflow forces internal reset
// - No direct write path to depth bit
// - Ten-bit return register, low byte shared
// - Return leaves return register unchanged
// - Reset does not clear return register
// - Shared word access spoils upper bits
// - Low reset pin resets; pulled high idle
// - Power-on detector drives reset pin low
// - Reset stops oscillator, output held low
package psq_pkg;
   localparam int          ADDR_W        = 10;
   localparam int          WORD_W        = 8;
   localparam int          LEN_W         = 2;
   localparam logic [9:0]  PC_RESET      = 10'h000;
   localparam logic        DEPTH_RESET   = 1'b0;
   localparam int          POC_HOLD_NS   = 1000;
   localparam int          CLK_NS        = 100;
   localparam int          POC_HOLD_CYC  = (POC_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  POC_HOLD_CNT  = 4'(POC_HOLD_CYC);
   localparam logic [2:0]  OP_NONE       = 3'h0;
   localparam logic [2:0]  OP_JMP_ALWAYS = 3'h1;
   localparam logic [2:0]  OP_JMP_CY     = 3'h2;
   localparam logic [2:0]  OP_JMP_NCY    = 3'h3;
   localparam logic [2:0]  OP_JMP_ST     = 3'h4;
   localparam logic [2:0]  OP_JMP_NST    = 3'h5;
   localparam logic [2:0]  OP_CALL       = 3'h6;
   localparam logic [2:0]  OP_EXIT       = 3'h7;
endpackage

// ### psq_reset_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module psq_reset_ctl (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pin_n,
   input  wire logic i_poc_trig,
   input  wire logic i_fault,
   output logic      o_sys_rst,
   output logic      o_pin_oe,
   output logic      o_osc_run
);
   logic [2:0] sync_reg;
   logic       pin_lvl_reg;
   logic [3:0] poc_cnt_reg;
   logic [3:0] poc_cnt_next;
   logic       pin_low_w;

   // Third stage only counts once second and third agree
   assign pin_low_w    = (sync_reg[2] == sync_reg[1]) ? ~sync_reg[2] : ~pin_lvl_reg;
   assign poc_cnt_next = i_poc_trig ? psq_pkg::POC_HOLD_CNT :
                         (poc_cnt_reg != 4'h0) ? poc_cnt_reg - 4'h1 : 4'h0;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_reg    <= 3'h7;
         pin_lvl_reg <= 1'b1;
         poc_cnt_reg <= 4'h0;
         o_sys_rst   <= 1'b1;
         o_pin_oe    <= 1'b0;
         o_osc_run   <= 1'b0;
      end else begin
         sync_reg    <= {sync_reg[1:0], i_pin_n};
         pin_lvl_reg <= ~pin_low_w;
         poc_cnt_reg <= poc_cnt_next;
         o_pin_oe    <= i_poc_trig | (poc_cnt_next != 4'h0);
         o_sys_rst   <= pin_low_w | i_poc_trig | (poc_cnt_next != 4'h0) | i_fault;
         o_osc_run   <= ~(pin_low_w | i_poc_trig | (poc_cnt_next != 4'h0) | i_fault);
      end
   end

   a_poc_drives_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_poc_trig |=> o_pin_oe && o_sys_rst)
      else $error("Detector did not drive pin");
   a_osc_stops_rst: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_sys_rst |-> !o_osc_run)
      else $error("Oscillator runs during reset");
   a_fault_resets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_fault |=> o_sys_rst)
      else $error("Fault did not reset");
endmodule
`default_nettype wire

// ### psq_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module psq_sequencer (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_reset_pin_n,
   input  wire logic                        i_power_on_detector,
   input  wire logic                        i_exec,
   input  wire logic [2:0]                  i_op,
   input  wire logic [psq_pkg::LEN_W-1:0]   i_len,
   input  wire logic [psq_pkg::ADDR_W-1:0]  i_target,
   input  wire logic                        i_carry,
   input  wire logic                        i_status,
   input  wire logic                        i_word_wr,
   input  wire logic                        i_word_rd,
   input  wire logic [psq_pkg::WORD_W-1:0]  i_word_wdata,
   output logic      [psq_pkg::ADDR_W-1:0]  o_program_address,
   output logic                             o_stack_depth_bit,
   output logic      [psq_pkg::WORD_W-1:0]  o_shared_last_data_word,
   output logic                             o_reset_pin_oe,
   output logic                             o_reset_pin_out,
   output logic                             o_osc_run,
   output logic                             o_osc_out,
   output logic                             o_sys_rst
);
   logic [psq_pkg::ADDR_W-1:0] program_address_reg;
   logic [psq_pkg::ADDR_W-1:0] program_address_next;
   logic                       stack_depth_bit;
   logic [psq_pkg::ADDR_W-1:0] return_address_reg;
   logic [1:0]                 ret_hi_known_reg;
   logic                       sys_rst_w;
   logic                       pin_oe_w;
   logic                       osc_run_w;
   logic                       osc_tgl_reg;
   logic                       is_call;
   logic                       is_exit;
   logic                       take_jump;
   logic                       fault_w;
   logic                       fault_reg;

   psq_reset_ctl u_rst (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_pin_n    (i_reset_pin_n),
      .i_poc_trig (i_power_on_detector),
      .i_fault    (fault_reg),
      .o_sys_rst  (sys_rst_w),
      .o_pin_oe   (pin_oe_w),
      .o_osc_run  (osc_run_w)
   );

   assign is_call   = i_exec && !sys_rst_w && (i_op == psq_pkg::OP_CALL);
   assign is_exit   = i_exec && !sys_rst_w && (i_op == psq_pkg::OP_EXIT);
   assign take_jump = i_exec && !sys_rst_w && (
                      (i_op == psq_pkg::OP_JMP_ALWAYS) ||
                      (i_op == psq_pkg::OP_JMP_CY  &&  i_carry) ||
                      (i_op == psq_pkg::OP_JMP_NCY && !i_carry) ||
                      (i_op == psq_pkg::OP_JMP_ST  &&  i_status) ||
                      (i_op == psq_pkg::OP_JMP_NST && !i_status));
   // Second call or unmatched return zeroes the address and resets the core
   assign fault_w   = (is_call && stack_depth_bit) || (is_exit && !stack_depth_bit);

   assign program_address_next =
      (sys_rst_w || fault_w) ? psq_pkg::PC_RESET :
      (take_jump || is_call) ? i_target :
      is_exit                ? return_address_reg :
      (i_exec)               ? program_address_reg + 10'(i_len) :
                               program_address_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         program_address_reg <= psq_pkg::PC_RESET;
         stack_depth_bit     <= psq_pkg::DEPTH_RESET;
         fault_reg           <= 1'b0;
      end else begin
         program_address_reg <= program_address_next;
         fault_reg           <= fault_w;
         // Only call, return and reset move depth; no write port exists
         if (sys_rst_w || fault_w)
            stack_depth_bit <= psq_pkg::DEPTH_RESET;
         else if (is_call)
            stack_depth_bit <= 1'b1;
         else if (is_exit)
            stack_depth_bit <= 1'b0;
      end
   end

   // No reset here: contents survive any reset
   always_ff @(posedge i_clk) begin
      // Saved address points past the call, else a return re-runs it
      if (is_call && !fault_w) begin
         return_address_reg <= program_address_reg + 10'(i_len);
         ret_hi_known_reg   <= 2'h3;
      end else if (i_word_wr) begin
         return_address_reg[7:0] <= i_word_wdata;
         ret_hi_known_reg        <= 2'h0;
      end else if (i_word_rd) begin
         ret_hi_known_reg <= 2'h0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_program_address       <= psq_pkg::PC_RESET;
         o_stack_depth_bit       <= psq_pkg::DEPTH_RESET;
         o_shared_last_data_word <= 8'h00;
         o_reset_pin_oe          <= 1'b0;
         o_reset_pin_out         <= 1'b0;
         o_osc_run               <= 1'b0;
         o_osc_out               <= 1'b0;
         o_sys_rst               <= 1'b1;
         osc_tgl_reg             <= 1'b0;
      end else begin
         o_program_address       <= program_address_next;
         o_stack_depth_bit       <= (sys_rst_w || fault_w) ? 1'b0 : is_call ? 1'b1 : is_exit ? 1'b0 : stack_depth_bit;
         o_shared_last_data_word <= return_address_reg[7:0];
         o_reset_pin_oe          <= pin_oe_w;
         o_reset_pin_out         <= 1'b0;
         o_osc_run               <= osc_run_w;
         osc_tgl_reg             <= osc_run_w ? ~osc_tgl_reg : 1'b0;
         o_osc_out               <= osc_run_w & ~osc_tgl_reg;
         o_sys_rst               <= sys_rst_w;
      end
   end

   a_call_loads_target: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (is_call && !stack_depth_bit) |=> program_address_reg == $past(i_target))
      else $error("Call target lost");
   a_exit_restores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (is_exit && stack_depth_bit) |=> program_address_reg == $past(return_address_reg))
      else $error("Exit bad");
   a_step_by_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_exec && !sys_rst_w && i_op == psq_pkg::OP_NONE) |=>
      program_address_reg == $past(program_address_reg) + 10'($past(i_len)))
      else $error("Bad advance");
   a_fault_zero_pc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      fault_w |=> program_address_reg == 10'h000 && !stack_depth_bit ##1 sys_rst_w)
      else $error("Fault no reset");
   a_jump_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      take_jump |=> program_address_reg == $past(i_target))
      else $error("Jump missed");
   a_exit_keeps_ret: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (is_exit && !i_word_wr) |=> $stable(return_address_reg))
      else $error("Return register changed");
   a_rst_zero_pc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sys_rst_w |=> program_address_reg == 10'h000 && !stack_depth_bit)
      else $error("Reset left state");
   a_depth_on_call: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (is_call && !stack_depth_bit) |=> stack_depth_bit)
      else $error("Depth not set");
   a_access_spoils_hi: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ((i_word_wr || i_word_rd) && !(is_call && !fault_w)) |=> ret_hi_known_reg == 2'h0)
      else $error("Upper return bits still marked known");
   c_call: cover property (@(posedge i_clk) is_call && !stack_depth_bit);
   c_call_exit: cover property (@(posedge i_clk) is_call ##[1:20] is_exit);
   c_fault: cover property (@(posedge i_clk) fault_w);
   c_poc: cover property (@(posedge i_clk) pin_oe_w);
endmodule
`default_nettype wire

// ### psq_decoder_model.sv
`timescale 1ns/100ps
`default_nettype none
module psq_decoder_model (
   input  wire logic       i_req,
   input  wire logic [2:0] i_req_op,
   input  wire logic [9:0] i_req_target,
   input  wire logic       i_sys_rst,
   input  wire logic       i_pin_oe,
   input  wire logic       i_pin_low,
   output logic            o_exec,
   output logic      [2:0] o_op,
   output logic      [9:0] o_target,
   output logic            o_pin_n
);
   // Decoder issues nothing while the core is held in reset
   assign o_exec   = i_req & ~i_sys_rst;
   // Released fields are scrambled, never left at the last value
   assign o_op     = i_req ? i_req_op : ~i_req_op;
   assign o_target = i_req ? i_req_target : ~i_req_target;
   // Pull-up idle, wired low by either party
   assign o_pin_n  = ~(i_pin_oe | i_pin_low);
endmodule
`default_nettype wire

// ### program_sequencer_call_stack_bench.sv
`timescale 1ns/100ps
`default_nettype none
module program_sequencer_call_stack_bench;
   logic        i_clk, i_rst_n = 1'b0, power_on_detector = 1'b0, req = 1'b0, cy = 1'b0, st = 1'b0;
   logic        pin_low = 1'b0, wr = 1'b0, rd = 1'b0, edep = 1'b0, unk = 1'b0, saved = 1'b0, t0 = 1'b0;
   logic [2:0]  r_op = 3'h0;
   logic [1:0]  r_len = 2'h0;
   logic [7:0]  wd = 8'h00;
   logic [9:0]  r_tg = 10'h000, epc = 10'h000, eret = 10'h000;
   logic [31:0] rnd = 32'hD408;
   int          n_mismatch = 0, checks = 0;
   wire         exec, pin_n, dep, oe, osc_run, osc_out, srst, pin_out;
   wire  [2:0]  op;
   wire  [9:0]  tg, pc;
   wire  [7:0]  word;
   psq_decoder_model psq_decoder_model_inst (.i_req(req), .i_req_op(r_op), .i_req_target(r_tg),
      .i_sys_rst(srst), .i_pin_oe(oe), .i_pin_low(pin_low), .o_exec(exec), .o_op(op), .o_target(tg),
      .o_pin_n(pin_n));
   psq_sequencer psq_sequencer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_pin_n(pin_n),
      .i_power_on_detector(power_on_detector), .i_exec(exec), .i_op(op), .i_len(r_len), .i_target(tg), .i_carry(cy),
      .i_status(st), .i_word_wr(wr), .i_word_rd(rd), .i_word_wdata(wd), .o_program_address(pc),
      .o_stack_depth_bit(dep), .o_shared_last_data_word(word), .o_reset_pin_oe(oe),
      .o_reset_pin_out(pin_out), .o_osc_run(osc_run), .o_osc_out(osc_out), .o_sys_rst(srst));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic taken(input logic [2:0] o, input logic c, input logic s);
      return o == 3'h1 || (o == 3'h2 && c) || (o == 3'h3 && !c) || (o == 3'h4 && s) || (o == 3'h5 && !s);
   endfunction
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Bounded wait for the internal reset to drop
   task automatic wait_idle;
      int k;
      k = 0;
      repeat (2) @(posedge i_clk);
      #1;
      while (srst !== 1'b0 && k < 60) begin
         @(posedge i_clk);
         #1;
         k++;
      end
      if (srst !== 1'b0) begin
         n_mismatch++;
         results();
      end
      @(posedge i_clk);
   endtask
   task automatic step(input logic [2:0] o, input logic [9:0] t);
      logic f;
      rnd = xs(rnd);
      @(posedge i_clk);
      req <= 1'b1;
      r_op <= o;
      r_tg <= t;
      r_len <= rnd[1:0];
      cy <= rnd[2];
      st <= rnd[3];
      @(posedge i_clk);
      req <= 1'b0;
      f = (o == 3'h6 && edep) || (o == 3'h7 && !edep);
      if (f) begin
         epc = 10'h000;
         edep = 1'b0;
      end else if (o == 3'h6) begin
         eret = epc + 10'(rnd[1:0]);
         epc = t;
         edep = 1'b1;
         unk = 1'b0;
         saved = 1'b1;
      end else if (o == 3'h7) begin
         epc = eret;
         edep = 1'b0;
      end else if (taken(o, rnd[2], rnd[3])) epc = t;
      else epc = epc + 10'(rnd[1:0]);
      #1;
      if (unk && o == 3'h7 && !f) chk({2'b0, pc[7:0]}, {2'b0, epc[7:0]});
      else chk(pc, epc);
      chk({9'h0, dep}, {9'h0, edep});
      @(posedge i_clk);
      #1;
      if (saved) chk({2'b0, word}, {2'b0, eret[7:0]});
      if (f) begin
         @(posedge i_clk);
         #1;
         chk({9'h0, srst}, 10'h001);
         wait_idle();
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      wait_idle();
      #1;
      chk(pc, 10'h000);
      chk({9'h0, dep}, 10'h000);
      t0 = osc_out;
      @(posedge i_clk);
      #1;
      chk({8'h0, osc_run, osc_out ^ t0}, 10'h003);
      for (int i = 0; i < 8; i++) step(3'(i), 10'(37 * i + 5));
      step(3'h6, 10'h2C4);
      step(3'h6, 10'h011);
      step(3'h7, 10'h022);
      $display("opcodes and stack faults done");
      step(3'h6, 10'h155);
      rnd = xs(rnd);
      @(posedge i_clk);
      wr <= 1'b1;
      wd <= rnd[15:8];
      @(posedge i_clk);
      wr <= 1'b0;
      rd <= 1'b1;
      eret[7:0] = rnd[15:8];
      unk = 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      step(3'h7, 10'h000);
      step(3'h1, 10'h3FF);
      step(3'h0, 10'h000);
      $display("shared word and wrap done");
      step(3'h6, 10'h2A0);
      @(posedge i_clk);
      pin_low <= 1'b1;
      repeat (8) @(posedge i_clk);
      #1;
      chk({9'h0, srst}, 10'h001);
      chk({8'h0, osc_run, osc_out}, 10'h000);
      @(posedge i_clk);
      pin_low <= 1'b0;
      wait_idle();
      epc = 10'h000;
      edep = 1'b0;
      #1;
      chk(pc, 10'h000);
      chk({9'h0, dep}, 10'h000);
      chk({2'b0, word}, {2'b0, eret[7:0]});
      @(posedge i_clk);
      power_on_detector <= 1'b1;
      @(posedge i_clk);
      power_on_detector <= 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      chk({7'h0, oe, pin_out, srst}, 10'h005);
      wait_idle();
      $display("pin and detector reset done");
      for (int i = 0; i < 80; i++) begin
         rnd = xs(rnd);
         step(rnd[10:8], rnd[29:20]);
      end
      $display("random sequence done");
      results();
   end
endmodule
`default_nettype wire
